// [core/fbd_decoder.sv]
// Fieldbus drive command decoder: slot routing, command word decode, drive state
// machine, reference and actual scaling, debug mirrors, APB register slave.
// Assumes cyclic data arrives as a frame strobe with all slots valid that cycle.
//
// How it works
// - Slots are 16-bit words, twelve each way
// - Each slot has its own content selector
// - Command bits steer drive state machine
// - Command word optionally converted before use
// - Debug fast mirrors command after optional conversion, status
// - References are two's complement words
// - Debug fast mirrors both raw references
// - Each reference scaled by its type
// - Two actual words, fixed to signals a and b
// - Debug fast mirrors scaled outgoing actuals
// - Actuals use the same scaling set
// - Bit 0 low gives ramp stop
// - Bit 1 low gives coast stop
// - Bit 2 low gives timed quick stop
// - Bit 3 runs only with run enable
// - Bit 4 low zeros ramp output
// - Bit 5 low holds ramp output
// - Bit 6 low zeros ramp input, if sourced
// - Bit 7 rising edge resets fault
// - Bit 8 jog one, ramp bits zero
// - Bit 9 jog two, same conditions
// - Bit 10 low ignores all but 0-2
// - Bit 11 picks secondary external location
// - Status bits 0-3 report drive state
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/100ps
module fbd_decoder
   import fbd_pkg::*;
#(
   parameter int unsigned SLOTS = FBD_SLOTS,
   parameter int unsigned QSTOP_CYC = FBD_QSTOP_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Cyclic data from the adapter
   input wire logic frame_valid,
   input wire logic [SLOTS*16-1:0] frame_out_words,
   output logic [SLOTS*16-1:0] frame_in_words,
   // Drive-side actual signals
   input wire logic [15:0] actual_sig_a,
   input wire logic [15:0] actual_sig_b,
   input wire logic fault_in,
   // Drive control outputs
   output logic run_enable,
   output logic ramp_out_zero,
   output logic ramp_hold,
   output logic ramp_in_zero,
   output logic jog_one,
   output logic jog_two,
   output logic external_location_secondary,
   output logic coast_stop_request,
   output logic quick_stop_request,
   output logic normal_stop_request,
   output logic [15:0] speed_ref1,
   output logic [15:0] speed_ref2
);

   ////////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [31:0] ctrl;
      logic [7:0] types; // [1:0] ref1 [3:2] ref2 [5:4] act1 [7:6] act2
      logic [SLOTS*4-1:0] sel_in;
      logic [SLOTS*4-1:0] sel_out;
      logic [15:0] command_word;
      logic [15:0] ref1_raw;
      logic [15:0] ref2_raw;
      logic [15:0] cmd_mir;
      logic [15:0] sts_mir;
      logic [31:0] ref_mir;
      logic [31:0] act_mir;
      logic [15:0] status_word;
      logic [15:0] act1;
      logic [15:0] act2;
      logic prev_reset;
      logic fault;
      fbd_state_t state;
      logic [15:0] qs_cnt;
      logic [SLOTS*16-1:0] in_words;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic run_enable;
      logic ramp_out_zero;
      logic ramp_hold;
      logic ramp_in_zero;
      logic jog_one;
      logic jog_two;
      logic loc2;
      logic coast;
      logic qstop;
      logic rstop;
      logic [15:0] sref1;
      logic [15:0] sref2;
   } fbd_regs_t;

   fbd_regs_t s_q;
   fbd_regs_t s_d;

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Scale a two's complement word by type; magnitude kept to 15 bits
   function automatic logic [15:0] fbd_scale(input logic [15:0] v, input logic [1:0] t);
      logic [15:0] r;
      r = v;
      case (fbd_type_t'(t))
         FBD_T_RAW: r = v;
         FBD_T_HALF: r = {v[15], v[15:1]};
         FBD_T_QUARTER: r = {{2{v[15]}}, v[15:2]};
         FBD_T_DOUBLE: r = {v[15], v[13:0], 1'b0};
         default: r = v;
      endcase
      return r;
   endfunction

   // Pick an inbound slot content by selector code
   function automatic logic [15:0] fbd_pick(input logic [3:0] code, input logic [15:0] sts,
      input logic [15:0] a1, input logic [15:0] a2);
      logic [15:0] r;
      r = 16'h0000;
      case (code)
         4'h1: r = sts;
         4'h2: r = a1;
         4'h3: r = a2;
         default: r = 16'h0000;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Outbound slot routing: every slot has its own selector code

   logic [SLOTS*16-1:0] route_cmd;
   logic [SLOTS*16-1:0] route_r1;
   logic [SLOTS*16-1:0] route_r2;
   logic [SLOTS*16-1:0] in_next;

   genvar g;
   generate
      for (g = 0; g < SLOTS; g++) begin : g_slot
         logic [3:0] so;
         logic [15:0] w;
         assign so = s_q.sel_out[g*4 +: 4];
         assign w = frame_out_words[g*16 +: 16];
         // Code 1 command, 2 reference one, 3 reference two; others unused
         assign route_cmd[g*16 +: 16] = (so == 4'h1) ? w : 16'h0000;
         assign route_r1[g*16 +: 16] = (so == 4'h2) ? w : 16'h0000;
         assign route_r2[g*16 +: 16] = (so == 4'h3) ? w : 16'h0000;
         assign in_next[g*16 +: 16] =
            fbd_pick(s_q.sel_in[g*4 +: 4], s_q.status_word, s_q.act1, s_q.act2);
      end
   endgenerate

   // OR-reduce routed slots; a double mapping ORs, which software must avoid
   logic [15:0] rx_cmd;
   logic [15:0] rx_r1;
   logic [15:0] rx_r2;
   always_comb begin
      rx_cmd = 16'h0000;
      rx_r1 = 16'h0000;
      rx_r2 = 16'h0000;
      for (int i = 0; i < SLOTS; i++) begin
         rx_cmd = rx_cmd | route_cmd[i*16 +: 16];
         rx_r1 = rx_r1 | route_r1[i*16 +: 16];
         rx_r2 = rx_r2 | route_r2[i*16 +: 16];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   logic [15:0] cw;
   logic rem;
   logic cmd_on;
   logic run_ok;
   logic rst_edge;
   logic [15:0] sw;
   logic apb_acc;
   logic [7:0] sel_off;
   logic [5:0] sel_i;
   logic sel_hit;
   logic apb_wr;

   always_comb begin
      s_d = s_q;
      cw = s_q.command_word;
      rem = cw[FBD_B_REMOTE];
      cmd_on = s_q.ctrl[FBD_C_CMD_SRC];
      run_ok = 1'b0;
      rst_edge = 1'b0;
      sw = 16'h0000;
      apb_acc = psel && penable && !s_q.pready;
      apb_wr = psel && penable && pwrite && s_q.pready;
      sel_off = paddr - ((paddr < FBD_A_SEL_OUT) ? FBD_A_SEL_IN : FBD_A_SEL_OUT);
      sel_i = sel_off[7:2];
      sel_hit = paddr >= FBD_A_SEL_IN && paddr < FBD_A_SEL_OUT + FBD_A_SEL_SPAN
         && paddr[1:0] == 2'h0;

      // Whole frame latched in one cycle, never partially
      if (frame_valid) begin
         s_d.command_word = s_q.ctrl[FBD_C_CONVERT] ? (rx_cmd ^ FBD_CONV_XOR) : rx_cmd;
         s_d.ref1_raw = rx_r1;
         s_d.ref2_raw = rx_r2;
      end

      // Reset edge: applied bit 7 against its value one cycle earlier
      s_d.prev_reset = cw[FBD_B_RESET];
      rst_edge = cmd_on && rem && s_q.ctrl[FBD_C_RST_SRC]
         && cw[FBD_B_RESET] && !s_q.prev_reset;

      // Stop requests; bits 0 to 2 act even without remote
      s_d.coast = cmd_on && !cw[FBD_B_COAST];
      s_d.qstop = cmd_on && cw[FBD_B_COAST] && !cw[FBD_B_QSTOP];
      s_d.rstop = cmd_on && cw[FBD_B_COAST] && cw[FBD_B_QSTOP]
         && !cw[FBD_B_RAMP_STOP];

      // Run enable drives from bus bit 3 when so configured
      run_ok = s_q.ctrl[FBD_C_RUNEN_SRC] ? (rem && cw[FBD_B_RUN])
         : s_q.ctrl[FBD_C_RUNEN_EXT];
      s_d.run_enable = run_ok;

      // Ramp controls, ignored unless remote
      s_d.ramp_out_zero = !(rem && cw[FBD_B_RAMP_OUT]);
      s_d.ramp_hold = !(rem && cw[FBD_B_RAMP_HOLD]);
      s_d.ramp_in_zero = s_q.ctrl[FBD_C_RAMPIN_SRC] && !(rem && cw[FBD_B_RAMP_IN]);
      // Jog only while ramp bits 4..6 are zero, as the controller must keep them
      s_d.jog_one = rem && cw[FBD_B_JOG1] && (cw[6:4] == 3'b000);
      s_d.jog_two = rem && cw[FBD_B_JOG2] && (cw[6:4] == 3'b000);
      if (s_q.ctrl[FBD_C_LOC_SRC] && rem) begin
         s_d.loc2 = cw[FBD_B_LOC];
      end

      // Fault capture; a new fault wins over a reset in the same cycle
      if (rst_edge) begin
         s_d.fault = 1'b0;
      end
      if (fault_in || s_q.ctrl[FBD_C_FAULT]) begin
         s_d.fault = 1'b1;
      end

      // Drive state machine
      if (s_q.qs_cnt != 16'h0000) begin
         s_d.qs_cnt = s_q.qs_cnt - 16'h0001;
      end
      if (s_q.fault) begin
         s_d.state = FBD_ST_FAULT;
      end else if (cmd_on) begin
         case (s_q.state)
            FBD_ST_FAULT: s_d.state = FBD_ST_INHIBIT;
            FBD_ST_COAST: s_d.state = FBD_ST_INHIBIT;
            FBD_ST_QSTOP: begin
               if (s_q.qs_cnt == 16'h0000) begin
                  s_d.state = FBD_ST_INHIBIT;
               end
            end
            default: begin
               if (s_q.coast) begin
                  s_d.state = FBD_ST_COAST;
               end else if (s_q.qstop) begin
                  if (s_q.state != FBD_ST_INHIBIT) begin
                     s_d.state = FBD_ST_QSTOP;
                     s_d.qs_cnt = 16'(QSTOP_CYC);
                  end
               end else if (s_q.rstop) begin
                  if (s_q.state == FBD_ST_OPER || s_q.state == FBD_ST_RDY_RUN) begin
                     s_d.state = FBD_ST_RAMP_STOP;
                  end else begin
                     s_d.state = FBD_ST_RDY_ON;
                  end
               end else begin
                  case (s_q.state)
                     FBD_ST_INHIBIT: s_d.state = FBD_ST_RDY_ON;
                     FBD_ST_RDY_ON: s_d.state = FBD_ST_RDY_RUN;
                     FBD_ST_RDY_RUN:
                        if (s_q.run_enable) s_d.state = FBD_ST_OPER;
                     FBD_ST_OPER:
                        if (!s_q.run_enable) s_d.state = FBD_ST_RDY_RUN;
                     default: s_d.state = FBD_ST_RDY_ON;
                  endcase
               end
            end
         endcase
      end

      // Status word from state
      sw[FBD_S_RDY_ON] = (s_q.state inside {FBD_ST_RDY_ON, FBD_ST_RDY_RUN, FBD_ST_OPER});
      sw[FBD_S_RDY_RUN] = (s_q.state inside {FBD_ST_RDY_RUN, FBD_ST_OPER});
      sw[FBD_S_OP_EN] = (s_q.state == FBD_ST_OPER);
      sw[FBD_S_FAULT] = s_q.fault;
      sw[FBD_S_COAST_OFF] = !s_q.coast;
      sw[FBD_S_QSTOP_OFF] = !s_q.qstop;
      sw[FBD_S_INHIBIT] = (s_q.state == FBD_ST_INHIBIT);
      sw[FBD_S_REMOTE] = rem;
      s_d.status_word = sw;

      // References scaled by type, zero when control not remote
      s_d.sref1 = rem ? fbd_scale(s_q.ref1_raw, s_q.types[1:0]) : 16'h0000;
      s_d.sref2 = rem ? fbd_scale(s_q.ref2_raw, s_q.types[3:2]) : 16'h0000;
      // Actuals taken from fixed signals a and b, scaled by type
      s_d.act1 = fbd_scale(actual_sig_a, s_q.types[5:4]);
      s_d.act2 = fbd_scale(actual_sig_b, s_q.types[7:6]);
      s_d.in_words = in_next;

      // Debug mirrors refresh only in fast mode
      if (s_q.ctrl[FBD_C_DEBUG]) begin
         s_d.cmd_mir = s_q.command_word;
         s_d.sts_mir = s_q.status_word;
         s_d.ref_mir = {s_q.ref2_raw, s_q.ref1_raw};
         s_d.act_mir = {s_q.act2, s_q.act1};
      end

      // Register slave, one wait state
      s_d.pready = apb_acc;
      s_d.pslverr = 1'b0;
      s_d.prdata = 32'h0000_0000;
      if (apb_acc) begin
         if (paddr == FBD_A_CTRL) begin
            s_d.prdata = s_q.ctrl;
         end else if (paddr == FBD_A_TYPES) begin
            s_d.prdata = {24'h00_0000, s_q.types};
         end else if (paddr == FBD_A_STATUS) begin
            s_d.prdata = {13'h0000, s_q.state, s_q.status_word};
         end else if (paddr == FBD_A_CMD_MIR) begin
            s_d.prdata = {16'h0000, s_q.cmd_mir};
         end else if (paddr == FBD_A_STS_MIR) begin
            s_d.prdata = {16'h0000, s_q.sts_mir};
         end else if (paddr == FBD_A_REF_MIR) begin
            s_d.prdata = s_q.ref_mir;
         end else if (paddr == FBD_A_ACT_MIR) begin
            s_d.prdata = s_q.act_mir;
         end else if (paddr == FBD_A_SCALED) begin
            s_d.prdata = {s_q.sref2, s_q.sref1};
         end else if (!sel_hit) begin
            s_d.pslverr = 1'b1;
         end
      end
      // Selector words, eight codes each
      for (int j = 0; j < SLOTS; j++) begin
         if (sel_hit && 6'(j / 8) == sel_i) begin
            if (paddr < FBD_A_SEL_OUT) begin
               if (apb_acc) s_d.prdata[(j % 8)*4 +: 4] = s_q.sel_in[j*4 +: 4];
               if (apb_wr) s_d.sel_in[j*4 +: 4] = pwdata[(j % 8)*4 +: 4];
            end else begin
               if (apb_acc) s_d.prdata[(j % 8)*4 +: 4] = s_q.sel_out[j*4 +: 4];
               if (apb_wr) s_d.sel_out[j*4 +: 4] = pwdata[(j % 8)*4 +: 4];
            end
         end
      end
      if (apb_wr && paddr == FBD_A_CTRL) s_d.ctrl = pwdata;
      if (apb_wr && paddr == FBD_A_TYPES) s_d.types = pwdata[7:0];
   end

   // State register; the all-zero reset is also the inhibit state
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) s_q <= '0;
      else s_q <= s_d;
   end

   // Every output straight from a flop
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign frame_in_words = s_q.in_words;
   assign run_enable = s_q.run_enable;
   assign ramp_out_zero = s_q.ramp_out_zero;
   assign ramp_hold = s_q.ramp_hold;
   assign ramp_in_zero = s_q.ramp_in_zero;
   assign jog_one = s_q.jog_one;
   assign jog_two = s_q.jog_two;
   assign external_location_secondary = s_q.loc2;
   assign coast_stop_request = s_q.coast;
   assign quick_stop_request = s_q.qstop;
   assign normal_stop_request = s_q.rstop;
   assign speed_ref1 = s_q.sref1;
   assign speed_ref2 = s_q.sref2;

endmodule // fbd_decoder

// [core/fbd_pkg.sv]
// Package for the fieldbus drive command decoder: register map, command word bit
// positions, status bits, type selectors and drive states.
// Assumes a 32-bit APB register bus, one word per register.
package fbd_pkg;
   // Slot geometry
   localparam int unsigned FBD_SLOTS = 12;
   localparam int unsigned FBD_WORD_W = 16;
   // Register byte offsets
   localparam logic [7:0] FBD_A_CTRL = 8'h00; // Source and mode settings
   localparam logic [7:0] FBD_A_TYPES = 8'h04; // Reference and actual type selectors
   localparam logic [7:0] FBD_A_STATUS = 8'h08; // Drive state and status word
   localparam logic [7:0] FBD_A_CMD_MIR = 8'h0C; // Command word mirror, after optional conversion
   localparam logic [7:0] FBD_A_STS_MIR = 8'h10; // Raw status word mirror
   localparam logic [7:0] FBD_A_REF_MIR = 8'h14; // Raw references mirror
   localparam logic [7:0] FBD_A_ACT_MIR = 8'h18; // Outgoing actuals mirror
   localparam logic [7:0] FBD_A_SCALED = 8'h1C; // Scaled references
   localparam logic [7:0] FBD_A_SEL_IN = 8'h20; // Inbound slot selectors, 12 x 4 bits
   localparam logic [7:0] FBD_A_SEL_OUT = 8'h40; // Outbound slot selectors
   localparam logic [7:0] FBD_A_SEL_SPAN = 8'h20; // Selector window length
   // Control register field positions
   localparam int unsigned FBD_C_CMD_SRC = 0; // Command word is the command source
   localparam int unsigned FBD_C_CONVERT = 1; // Apply conversion to command word
   localparam int unsigned FBD_C_DEBUG = 2; // Debug mode fast
   localparam int unsigned FBD_C_RUNEN_SRC = 3; // Run enable from bus
   localparam int unsigned FBD_C_RAMPIN_SRC = 4; // Ramp-in-zero from bus
   localparam int unsigned FBD_C_RST_SRC = 5; // Fault reset from bus
   localparam int unsigned FBD_C_LOC_SRC = 6; // Location select from bus
   localparam int unsigned FBD_C_RUNEN_EXT = 7; // Run enable when not from bus
   localparam int unsigned FBD_C_FAULT = 8; // Software raises a fault
   localparam logic [31:0] FBD_CTRL_RST = 32'h0000_0000;
   // Command word bits
   localparam int unsigned FBD_B_RAMP_STOP = 0;
   localparam int unsigned FBD_B_COAST = 1;
   localparam int unsigned FBD_B_QSTOP = 2;
   localparam int unsigned FBD_B_RUN = 3;
   localparam int unsigned FBD_B_RAMP_OUT = 4;
   localparam int unsigned FBD_B_RAMP_HOLD = 5;
   localparam int unsigned FBD_B_RAMP_IN = 6;
   localparam int unsigned FBD_B_RESET = 7;
   localparam int unsigned FBD_B_JOG1 = 8;
   localparam int unsigned FBD_B_JOG2 = 9;
   localparam int unsigned FBD_B_REMOTE = 10;
   localparam int unsigned FBD_B_LOC = 11;
   // Conversion mask: forces the three stop bits low-active sense inverted
   localparam logic [15:0] FBD_CONV_XOR = 16'h0007;
   // Status word bits
   localparam int unsigned FBD_S_RDY_ON = 0;
   localparam int unsigned FBD_S_RDY_RUN = 1;
   localparam int unsigned FBD_S_OP_EN = 2;
   localparam int unsigned FBD_S_FAULT = 3;
   localparam int unsigned FBD_S_COAST_OFF = 4;
   localparam int unsigned FBD_S_QSTOP_OFF = 5;
   localparam int unsigned FBD_S_INHIBIT = 6;
   localparam int unsigned FBD_S_REMOTE = 9;
   // Scaling type selectors (shift applied to a 15-bit magnitude)
   typedef enum logic [1:0] {
      FBD_T_RAW,
      FBD_T_HALF,
      FBD_T_QUARTER,
      FBD_T_DOUBLE
   } fbd_type_t;
   // Drive operating states
   typedef enum logic [2:0] {
      FBD_ST_INHIBIT,
      FBD_ST_RDY_ON,
      FBD_ST_RDY_RUN,
      FBD_ST_OPER,
      FBD_ST_RAMP_STOP,
      FBD_ST_COAST,
      FBD_ST_QSTOP,
      FBD_ST_FAULT
   } fbd_state_t;
   // Quick stop time
   localparam int unsigned FBD_QSTOP_NS = 2000;
   localparam int unsigned FBD_CLK_NS = 8;
   localparam int unsigned FBD_QSTOP_CYC = FBD_QSTOP_NS / FBD_CLK_NS;
endpackage

// [dv/fbd_chk.sv]
// Checker for the fieldbus drive command decoder, bound to its top ports.
// Assumes decoded outputs move only shortly after a frame, an APB write or a fault.
`timescale 1ns/100ps
module fbd_chk
   import fbd_pkg::*;
#(
   parameter int unsigned SLOTS = FBD_SLOTS
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   // Causes
   input wire logic frame_valid,
   input wire logic fault_in,
   // Decoded outputs
   input wire logic jog_one,
   input wire logic coast_stop_request,
   input wire logic quick_stop_request,
   input wire logic normal_stop_request,
   input wire logic [15:0] speed_ref1,
   input wire logic [15:0] speed_ref2
);
   logic [3:0] quiet_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////////////
   // Cycles since the last cause; timed stops are left out since they end on their own
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) quiet_q <= 4'h0;
      else if (frame_valid || fault_in || (psel && penable && pwrite)) quiet_q <= 4'h0;
      else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   stop_cq_excl_a: assert property (!(coast_stop_request && quick_stop_request))
      else $error("coast and quick stop requested together");
   stop_qn_excl_a: assert property (!(quick_stop_request && normal_stop_request))
      else $error("quick and normal stop requested together");
   stop_cn_excl_a: assert property (!(coast_stop_request && normal_stop_request))
      else $error("coast and normal stop requested together");
   apb_answer_a: assert property (psel && penable |-> ##[0:15] pready)
      else $error("register access not answered");
   coast_cause_a: assert property ($changed(coast_stop_request) |-> quiet_q < 4'hC)
      else $error("coast request moved without a frame");
   jog_cause_a: assert property ($changed(jog_one) |-> quiet_q < 4'hC)
      else $error("jog moved without a frame");
   ref1_cause_a: assert property ($changed(speed_ref1) |-> quiet_q < 4'hC)
      else $error("reference one moved without a frame");
   ref2_cause_a: assert property ($changed(speed_ref2) |-> quiet_q < 4'hC)
      else $error("reference two moved without a frame");
endmodule // fbd_chk

// [dv/fbd_master_model.sv]
// Fieldbus controller model: sends whole frames of twelve slots to the decoder.
// Assumes slot 0 carries the command word, slots 1 and 2 the references.
`timescale 1ns/100ps
module fbd_master_model
   import fbd_pkg::*;
#(
   parameter int unsigned SLOTS = FBD_SLOTS
) (
   // Clock
   input wire logic ref_clk,
   // Cyclic data
   output logic frame_valid,
   output logic [SLOTS*16-1:0] frame_out_words,
   input wire logic [SLOTS*16-1:0] frame_in_words
);
   logic [SLOTS*16-1:0] last_q;
   initial begin
      frame_valid = 1'b0;
      frame_out_words = '0;
      last_q = '0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // One strobe cycle per frame; outside it the lines toggle so stale data is useless
   task automatic send_frame(input logic [15:0] cw, input logic [15:0] r1,
                             input logic [15:0] r2, input int gap);
      logic [SLOTS*16-1:0] w;
      w = ~last_q;
      w[47:0] = {r2, r1, cw};
      @(posedge ref_clk);
      frame_valid <= 1'b1;
      frame_out_words <= w;
      @(posedge ref_clk);
      frame_valid <= 1'b0;
      frame_out_words <= ~w;
      last_q <= w;
      repeat (gap) @(posedge ref_clk);
   endtask
endmodule // fbd_master_model

// [dv/test_fbd_decoder.sv]
// Testbench for the fieldbus drive command decoder.
// Assumes selector code 1/2/3 picks command/ref1/ref2 and ref1 type sits in bits 1:0.
`timescale 1ns/100ps
module test_fbd_decoder
   import fbd_pkg::*;
;
   localparam logic [31:0] SEL_MAP = 32'h0000_0321;
   localparam logic [31:0] CTRL_ON = 32'h0000_007D;
   logic ref_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic fault_in = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, frame_valid, run_enable, ramp_out_zero, ramp_hold, ramp_in_zero;
   logic jog_one, jog_two, ext_sec, coast, quick, normal;
   logic [FBD_SLOTS*16-1:0] fout, fin;
   logic [15:0] ref1, ref2;
   int n_fail = 0, tests_run = 0;
   logic [31:0] q;
   logic e;
   wire logic [41:0] obs = {run_enable, ramp_out_zero, ramp_hold, ramp_in_zero, jog_one,
                            jog_two, ext_sec, coast, quick, normal, ref1, ref2};
   always #4 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////////////////////
   // Design and controller model; actual inputs held constant
   fbd_decoder i_dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .frame_valid(frame_valid), .frame_out_words(fout),
      .frame_in_words(fin), .actual_sig_a(16'h1234), .actual_sig_b(16'h0567),
      .fault_in(fault_in), .run_enable(run_enable), .ramp_out_zero(ramp_out_zero),
      .ramp_hold(ramp_hold), .ramp_in_zero(ramp_in_zero), .jog_one(jog_one),
      .jog_two(jog_two), .external_location_secondary(ext_sec),
      .coast_stop_request(coast), .quick_stop_request(quick),
      .normal_stop_request(normal), .speed_ref1(ref1), .speed_ref2(ref2));
   fbd_master_model i_master (.ref_clk(ref_clk), .frame_valid(frame_valid),
      .frame_out_words(fout), .frame_in_words(fin));
   ////////////////////////////////////////////////////////////////////////////////
   // Shared compare, bus cycle and bounded output wait
   task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_out(input string what, input logic [41:0] m, input logic [41:0] exp);
      for (int i = 0; i < 16 && ((obs & m) !== exp); i++) @(posedge ref_clk);
      check(what, 48'(exp), 48'(obs & m));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_setup();
      apb(1'b1, FBD_A_SEL_IN, SEL_MAP, q, e);
      apb(1'b1, FBD_A_SEL_OUT, SEL_MAP, q, e);
      apb(1'b1, FBD_A_CTRL, CTRL_ON, q, e);
      apb(1'b0, FBD_A_SEL_IN, 32'h0, q, e);
      check("selector readback", 48'(SEL_MAP), 48'(q));
      check("inbound slots", 48'h0567_1234, 48'(fin[47:16]));
      apb(1'b0, 8'hFC, 32'h0, q, e);
      check("unmapped error", 48'h1, 48'(e));
   endtask
   task automatic t_stops();
      logic [2:0] s;
      for (int i = 0; i < 8; i++) begin
         s = i[2:0];
         i_master.send_frame(16'h0478 | 16'(s), 16'h0000, 16'h0000, i);
         wait_out("stop requests", 42'h7 << 32,
                  42'({~s[1], s[1] & ~s[2], s[1] & s[2] & ~s[0]}) << 32);
      end
      // Conversion inverts the three stop bits, so this raw word means no stop
      apb(1'b1, FBD_A_CTRL, CTRL_ON | 32'h2, q, e);
      i_master.send_frame(16'h0478, 16'h0000, 16'h0000, 2);
      wait_out("converted stops", 42'h7 << 32, 42'h0);
      apb(1'b1, FBD_A_CTRL, CTRL_ON, q, e);
   endtask
   task automatic t_bits();
      logic [15:0] cw[3] = '{16'h0F0F, 16'h047F, 16'h0B0D};
      logic [9:0] ex[3] = '{10'h3F8, 10'h200, 10'h004};
      logic [9:0] mk[3] = '{10'h3FF, 10'h3FF, 10'h034};
      for (int i = 0; i < 3; i++) begin
         i_master.send_frame(cw[i], 16'h0000, 16'h0000, 1);
         wait_out("control outputs", 42'(mk[i]) << 32, 42'(ex[i]) << 32);
      end
   endtask
   task automatic t_refs();
      logic [15:0] sc[4] = '{16'hFF9C, 16'hFFCE, 16'hFFE7, 16'hFF38};
      for (int t = 0; t < 4; t++) begin
         apb(1'b1, FBD_A_TYPES, 32'(t) * 32'h11, q, e);
         i_master.send_frame(16'h047F, 16'hFF9C, 16'h0064, 3);
         wait_out("scaled references", 42'hFFFF_FFFF, 42'({sc[t], 16'h0064}));
      end
      apb(1'b0, FBD_A_CMD_MIR, 32'h0, q, e);
      check("command mirror", 48'h047F, 48'(q[15:0]));
      apb(1'b0, FBD_A_REF_MIR, 32'h0, q, e);
      check("reference mirror", 48'h0064_FF9C, 48'(q));
      apb(1'b0, FBD_A_ACT_MIR, 32'h0, q, e);
      check("actual mirror", 48'h0567_2468, 48'(q));
   endtask
   task automatic t_fault();
      @(posedge ref_clk);
      fault_in <= 1'b1;
      repeat (4) @(posedge ref_clk);
      apb(1'b0, FBD_A_STATUS, 32'h0, q, e);
      check("fault status", 48'h1, 48'(q[FBD_S_FAULT]));
      fault_in <= 1'b0;
      i_master.send_frame(16'h047F, 16'h0000, 16'h0000, 2);
      i_master.send_frame(16'h04FF, 16'h0000, 16'h0000, 8);
      apb(1'b0, FBD_A_STATUS, 32'h0, q, e);
      check("fault after reset edge", 48'h0, 48'(q[FBD_S_FAULT]));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Verdict, sequence and watchdog
   task automatic summarize();
      $display("checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge ref_clk);
      rstn <= 1'b1;
      t_setup();
      t_stops();
      t_bits();
      t_refs();
      t_fault();
      summarize();
   end
   initial begin
      #200000;
      n_fail++;
      summarize();
   end
endmodule // test_fbd_decoder
bind fbd_decoder fbd_chk #(.SLOTS(SLOTS)) i_chk (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pready(pready), .frame_valid(frame_valid),
   .fault_in(fault_in), .jog_one(jog_one), .coast_stop_request(coast_stop_request),
   .quick_stop_request(quick_stop_request), .normal_stop_request(normal_stop_request),
   .speed_ref1(speed_ref1), .speed_ref2(speed_ref2));
